/* design/pho_defines.svh */
`ifndef PHO_DEFINES_SVH
`define PHO_DEFINES_SVH

// Register offsets
`define PHO_OFF_LDCAL   8'h18
`define PHO_OFF_LDSEL   8'h1a
`define PHO_OFF_RMON    8'h1b
`define PHO_OFF_REFIN   8'h1c
`define PHO_OFF_HOLD    8'h1d
`define PHO_OFF_STAT    8'h1f

// Field positions
`define PHO_LD_DIS      3
`define PHO_LD_CNT_LO   5
`define PHO_LDSEL_THR   6
`define PHO_REFIN_BUF1  1
`define PHO_REFIN_BUF2  2
`define PHO_REFIN_SE    3
`define PHO_REFIN_SEL   4
`define PHO_REFIN_EXT   5
`define PHO_HOLD_EN0    0
`define PHO_HOLD_EXT    1
`define PHO_HOLD_EN2    2
`define PHO_HOLD_CMP    3

// Field codes and reset value
`define PHO_LDSEL_CSRC  6'h04
`define PHO_RMON_REF1N  8'hf7
`define PHO_RST_REG     8'h00

// Lock detect counts for codes 00b..11b
`define PHO_LD_CYC0     5
`define PHO_LD_CYC1     16
`define PHO_LD_CYC2     64
`define PHO_LD_CYC3     255

// Frequency monitor timing
`define PHO_CLK_NS      10
`define PHO_MON_WIN_NS  1000
`define PHO_MON_WIN_CYC (`PHO_MON_WIN_NS / `PHO_CLK_NS)
`define PHO_MON_THR_NRM 8
`define PHO_MON_THR_EXT 2

`endif

/* design/pho_pkg.sv */
package pho_pkg;

    typedef enum logic [2:0]
    {
        PHO_RUN   = 3'b001,
        PHO_HOLD  = 3'b010,
        PHO_REARM = 3'b100
    } pho_hold_state_t;

endpackage

/* design/pho_holdover.sv */
`timescale 1ns/100ps
`include "pho_defines.svh"

module pho_holdover
    import pho_pkg::*;
#(
    parameter int MON_WIN_CYC = `PHO_MON_WIN_CYC,
    parameter int MON_THR_NRM = `PHO_MON_THR_NRM,
    parameter int MON_THR_EXT = `PHO_MON_THR_EXT
)
(
    // Clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       reset_n_i,
    // Register port
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    // Loop events and pins
    input  wire logic       sync_n_i,
    input  wire logic       first_reference_edge_i,
    input  wire logic       second_reference_edge_i,
    input  wire logic       pfd_cycle_i,
    input  wire logic       pfd_in_lock_win_i,
    input  wire logic       pfd_over_unlock_win_i,
    input  wire logic       lock_pin_high_i,
    input  wire logic       vco_tick_i,
    input  wire logic       ext_clk_tick_i,
    input  wire logic       vco_cal_done_i,
    // Loop controls
    output logic            charge_pump_hiz_o,
    output logic            b_counter_reset_o,
    output logic            digital_lock_detect_o,
    output logic            selected_ref_o,
    // Pin drives
    output logic            lock_pin_level_o,
    output logic            lock_pin_source_o,
    output logic            lock_pin_discharge_o,
    output logic            reference_monitor_pin_o,
    output logic            first_reference_buf_en_o,
    output logic            second_reference_buf_en_o
);

    ////////////////////////////////////////////////////////////////////////
    logic [7:0]      lock_detect_and_cal_control;
    logic [7:0]      lock_pin_output_select;
    logic [7:0]      reference_monitor_pin_control;
    logic [7:0]      reference_input_control;
    logic [7:0]      holdover_control;
    logic [7:0]      pll_readback_status;
    logic [7:0]      lock_cnt;
    logic [7:0]      lock_need;
    logic            hold_en;
    logic            manual;
    logic            cmp_en;
    logic            lock_sensed;
    logic            csrc_mode;
    logic            ref_edge;
    logic            sel_prev;
    logic            ref_switch;
    logic            sync_prev;
    logic            sync_fall;
    logic            leave_hold;
    logic [2:0]      mon_tick;
    logic [2:0]      mon_low;
    logic [15:0]     win_cnt;
    logic            win_end;
    logic [7:0]      mon_thr;
    pho_hold_state_t state;
    pho_hold_state_t next_state;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    ////////////////////////////////////////////////////////////////////////
    // Register writes
    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            lock_detect_and_cal_control   <= `PHO_RST_REG;
            lock_pin_output_select        <= `PHO_RST_REG;
            reference_monitor_pin_control <= `PHO_RST_REG;
            reference_input_control       <= `PHO_RST_REG;
            holdover_control              <= `PHO_RST_REG;
        end
        else if (reg_wr_i)
        begin
            if (reg_addr_i == `PHO_OFF_LDCAL)
                lock_detect_and_cal_control <= reg_wdata_i;
            else if (reg_addr_i == `PHO_OFF_LDSEL)
                lock_pin_output_select <= reg_wdata_i;
            else if (reg_addr_i == `PHO_OFF_RMON)
                reference_monitor_pin_control <= reg_wdata_i;
            else if (reg_addr_i == `PHO_OFF_REFIN)
                reference_input_control <= reg_wdata_i;
            else if (reg_addr_i == `PHO_OFF_HOLD)
                holdover_control <= reg_wdata_i;
        end
    end

    // Readback: lock, monitors, holdover state, calibration done
    always_comb
    begin
        pll_readback_status      = 8'h00;
        pll_readback_status[0]   = digital_lock_detect_o;
        pll_readback_status[3:1] = mon_low;
        pll_readback_status[4]   = charge_pump_hiz_o;
        pll_readback_status[6]   = vco_cal_done_i;
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i || !reg_rd_i)
            reg_rdata_o <= 8'h00;
        else if (reg_addr_i == `PHO_OFF_LDCAL)
            reg_rdata_o <= lock_detect_and_cal_control;
        else if (reg_addr_i == `PHO_OFF_LDSEL)
            reg_rdata_o <= lock_pin_output_select;
        else if (reg_addr_i == `PHO_OFF_RMON)
            reg_rdata_o <= reference_monitor_pin_control;
        else if (reg_addr_i == `PHO_OFF_REFIN)
            reg_rdata_o <= reference_input_control;
        else if (reg_addr_i == `PHO_OFF_HOLD)
            reg_rdata_o <= holdover_control;
        else if (reg_addr_i == `PHO_OFF_STAT)
            reg_rdata_o <= pll_readback_status;
        else
            reg_rdata_o <= 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // Reference selection and buffers
    assign ref_edge   = selected_ref_o ? second_reference_edge_i : first_reference_edge_i;
    assign ref_switch = sel_prev != selected_ref_o;

    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            selected_ref_o <= 1'b0;
            sel_prev       <= 1'b0;
            first_reference_buf_en_o  <= 1'b0;
            second_reference_buf_en_o  <= 1'b0;
        end
        else
        begin
            selected_ref_o <= reference_input_control[`PHO_REFIN_SEL];
            sel_prev       <= selected_ref_o;
            first_reference_buf_en_o  <= reference_input_control[`PHO_REFIN_BUF1];
            second_reference_buf_en_o  <= reference_input_control[`PHO_REFIN_BUF2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Digital lock detect
    always_comb
    begin
        case (lock_detect_and_cal_control[`PHO_LD_CNT_LO +: 2])
            2'b00:   lock_need = 8'(`PHO_LD_CYC0);
            2'b01:   lock_need = 8'(`PHO_LD_CYC1);
            2'b10:   lock_need = 8'(`PHO_LD_CYC2);
            default: lock_need = 8'(`PHO_LD_CYC3);
        endcase
    end

    // A switchover drops lock so holdover bridges the gap
    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i || lock_detect_and_cal_control[`PHO_LD_DIS] || ref_switch)
        begin
            lock_cnt              <= 8'h00;
            digital_lock_detect_o <= 1'b0;
        end
        else if (pfd_cycle_i)
        begin
            if (pfd_over_unlock_win_i)
            begin
                lock_cnt              <= 8'h00;
                digital_lock_detect_o <= 1'b0;
            end
            else if (pfd_in_lock_win_i)
            begin
                if (lock_cnt + 8'h01 >= lock_need)
                    digital_lock_detect_o <= 1'b1;
                else
                    lock_cnt <= lock_cnt + 8'h01;
            end
            else
                lock_cnt <= 8'h00;
        end
    end

    // Lock indicator pin drive
    assign csrc_mode = lock_pin_output_select[5:0] == `PHO_LDSEL_CSRC;

    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            lock_pin_level_o     <= 1'b0;
            lock_pin_source_o    <= 1'b0;
            lock_pin_discharge_o <= 1'b0;
        end
        else
        begin
            lock_pin_level_o     <= !csrc_mode && digital_lock_detect_o;
            lock_pin_source_o    <= csrc_mode && digital_lock_detect_o;
            lock_pin_discharge_o <= csrc_mode && !digital_lock_detect_o;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Holdover control
    assign hold_en     = holdover_control[`PHO_HOLD_EN0]
                         && holdover_control[`PHO_HOLD_EN2];
    assign manual      = holdover_control[`PHO_HOLD_EXT];
    assign cmp_en      = holdover_control[`PHO_HOLD_CMP];
    assign lock_sensed = cmp_en ? lock_pin_high_i : 1'b1;
    assign sync_fall   = sync_prev && !sync_n_i;
    // Level alone never enters, only the falling edge
    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i)
            sync_prev <= 1'b1;
        else
            sync_prev <= sync_n_i;
    end

    always_comb
    begin
        next_state = state;
        leave_hold = 1'b0;
        case (state)
            PHO_RUN:
            begin
                if (hold_en && manual && sync_fall)
                    next_state = PHO_HOLD;
                else if (hold_en && !manual && !lock_sensed)
                    next_state = PHO_HOLD;
            end
            PHO_HOLD:
            begin
                if (!hold_en)
                    next_state = PHO_RUN;
                else if (ref_edge && (!manual || sync_n_i))
                begin
                    // No edge, no exit unless holdover is disabled: stays high impedance
                    leave_hold = 1'b1;
                    next_state = manual ? PHO_RUN : PHO_REARM;
                end
            end
            PHO_REARM:
            begin
                if (!hold_en || manual)
                    next_state = PHO_RUN;
                else if (digital_lock_detect_o && lock_sensed)
                    next_state = PHO_RUN;
            end
            default: next_state = PHO_RUN;
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            state             <= PHO_RUN;
            charge_pump_hiz_o <= 1'b0;
            b_counter_reset_o <= 1'b0;
        end
        else
        begin
            state             <= next_state;
            charge_pump_hiz_o <= next_state == PHO_HOLD;
            b_counter_reset_o <= leave_hold;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frequency monitors over a shared window
    assign win_end = win_cnt == 16'(MON_WIN_CYC - 1);
    assign mon_thr = lock_pin_output_select[`PHO_LDSEL_THR]
                     ? 8'(MON_THR_EXT) : 8'(MON_THR_NRM);
    assign mon_tick[0] = first_reference_edge_i;
    assign mon_tick[1] = second_reference_edge_i;
    // External clock is watched when it feeds the N divider
    assign mon_tick[2] = reference_input_control[`PHO_REFIN_EXT]
                         ? ext_clk_tick_i : vco_tick_i;

    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i || win_end)
            win_cnt <= 16'h0000;
        else
            win_cnt <= win_cnt + 16'h0001;
    end

    generate
        for (genvar i = 0; i < 3; i++)
        begin : g_mon
            logic [7:0] tick_cnt;
            logic       low_flag;
            always_ff @(posedge core_clk_i)
            begin
                if (!reset_n_i)
                begin
                    tick_cnt <= 8'h00;
                    low_flag <= 1'b0;
                end
                else if (win_end)
                begin
                    tick_cnt <= 8'h00;
                    low_flag <= tick_cnt < mon_thr;
                end
                else if (mon_tick[i] && tick_cnt != 8'hff)
                    tick_cnt <= tick_cnt + 8'h01;
            end
        end
    endgenerate

    // Second reference only monitored in single-ended mode
    assign mon_low[0] = g_mon[0].low_flag;
    assign mon_low[1] = g_mon[1].low_flag
                        && reference_input_control[`PHO_REFIN_SE];
    assign mon_low[2] = g_mon[2].low_flag;

    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i)
            reference_monitor_pin_o <= 1'b0;
        else
            reference_monitor_pin_o <= (reference_monitor_pin_control == `PHO_RMON_REF1N)
                                       && mon_low[0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_in_win;
        pfd_cycle_i && pfd_in_lock_win_i && !pfd_over_unlock_win_i && !ref_switch
        && !lock_detect_and_cal_control[`PHO_LD_DIS]
        && lock_detect_and_cal_control[`PHO_LD_CNT_LO +: 2] == 2'b00;
    endsequence

    // Independent count of consecutive in-window detector cycles
    logic [2:0] run_cnt;
    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i || ref_switch || lock_detect_and_cal_control[`PHO_LD_DIS])
            run_cnt <= 3'h0;
        else if (pfd_cycle_i)
            run_cnt <= (pfd_in_lock_win_i && !pfd_over_unlock_win_i) ? run_cnt + 3'h1 : 3'h0;
    end

    sequence s_manual_trig;
        state == PHO_RUN && hold_en && manual && sync_fall;
    endsequence

    chk_manual_entry: assert property (s_manual_trig |=> charge_pump_hiz_o)
        else $error("manual holdover not entered");
    chk_disabled_quiet: assert property (!hold_en |=> !charge_pump_hiz_o)
        else $error("holdover active while disabled");
    chk_exit_breset: assert property ($fell(charge_pump_hiz_o) && $past(hold_en)
        |-> b_counter_reset_o)
        else $error("no B counter reset on exit");
    chk_manual_wait: assert property (charge_pump_hiz_o && hold_en && manual && !sync_n_i
        |=> charge_pump_hiz_o)
        else $error("manual holdover left while pin low");
    chk_no_ref_stay: assert property (charge_pump_hiz_o && hold_en && !ref_edge
        |=> charge_pump_hiz_o)
        else $error("holdover left without reference edge");
    chk_auto_entry: assert property (state == PHO_RUN && hold_en && !manual
        && !lock_sensed |=> charge_pump_hiz_o)
        else $error("automatic holdover not entered");
    chk_cmp_off: assert property (state == PHO_RUN && hold_en && !manual && !cmp_en
        |=> !charge_pump_hiz_o)
        else $error("entry with comparator disabled");
    chk_rearm_block: assert property (state == PHO_REARM
        && !(digital_lock_detect_o && lock_sensed) |=> !charge_pump_hiz_o)
        else $error("re-entry before lock regained");
    chk_five_cycles: assert property (s_in_win ##0 run_cnt == 3'h4 |=> digital_lock_detect_o)
        else $error("lock not declared after five cycles");
    chk_unlock_drop: assert property (pfd_cycle_i && pfd_over_unlock_win_i
        |=> !digital_lock_detect_o)
        else $error("lock kept after unlock cycle");
    chk_csrc_drive: assert property (csrc_mode && !digital_lock_detect_o
        |=> lock_pin_discharge_o && !lock_pin_source_o)
        else $error("lock pin not discharged");
    chk_reference_monitor_pin_pin: assert property (reference_monitor_pin_control == `PHO_RMON_REF1N
        |=> reference_monitor_pin_o == $past(mon_low[0]))
        else $error("monitor pin wrong for first reference");

endmodule

/* dv/pho_loop_model.sv */
`timescale 1ns/100ps
module pho_loop_model
#(
    parameter int CHG_CYC = 4
)
(
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic reset_n_i,
    // Bench controls
    input  wire logic ref_on_i,
    input  wire logic in_win_i,
    // Lock pin drive from the block
    input  wire logic src_i,
    input  wire logic dis_i,
    // Loop events towards the block
    output logic      first_reference_edge_o,
    output logic      pfd_cycle_o,
    output logic      in_win_o,
    output logic      over_win_o,
    output logic      lock_pin_high_o,
    output logic      vco_tick_o
);
    logic [1:0] div;
    logic [3:0] cap;

    always_ff @(posedge core_clk_i)
    begin
        div         <= reset_n_i ? div + 2'h1 : 2'h0;
        first_reference_edge_o <= reset_n_i && ref_on_i && div == 2'h3;
        vco_tick_o  <= reset_n_i && div[0];
    end

    // Detector compares only when a reference edge arrives
    assign pfd_cycle_o = first_reference_edge_o;
    assign in_win_o    = first_reference_edge_o && in_win_i;
    assign over_win_o  = first_reference_edge_o && !in_win_i;

    // Capacitor ramps while sourced and dumps at once on discharge
    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i || dis_i)
            cap <= 4'h0;
        else if (src_i && cap != CHG_CYC[3:0])
            cap <= cap + 4'h1;
    end

    assign lock_pin_high_o = cap == CHG_CYC[3:0];
endmodule

/* dv/pho_holdover_bench.sv */
`timescale 1ns/100ps
module pho_holdover_bench
    import pho_pkg::*;
;
    typedef struct packed
    {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] want;
    } pho_row_t;

    localparam pho_row_t ROWS [6] = '{'{8'h18, 8'h60, 8'h60}, '{8'h1a, 8'h44, 8'h44},
        '{8'h1b, 8'hf7, 8'hf7}, '{8'h1c, 8'h06, 8'h06}, '{8'h1d, 8'h08, 8'h08},
        '{8'h20, 8'hff, 8'h00}};
    localparam logic [7:0] OFF_CODES [2] = '{8'h03, 8'h06};

    logic       clk, rst_n, wr, rd, sync_n, ref_on, in_win, cal_done;
    logic [7:0] addr, wdata, rdata, v;
    logic       hiz, brst, digital_lock_detect, selref, lvl, src, dis, mon, b1, b2;
    logic       r1, pc, iw, ow, lph, vt;
    int         num_errors, compares, n;

    always #5 clk = ~clk;

    pho_holdover #(.MON_WIN_CYC(20), .MON_THR_NRM(4), .MON_THR_EXT(2)) dut_u (
        .core_clk_i(clk), .reset_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .sync_n_i(sync_n),
        .first_reference_edge_i(r1), .second_reference_edge_i(1'b0), .pfd_cycle_i(pc), .pfd_in_lock_win_i(iw),
        .pfd_over_unlock_win_i(ow), .lock_pin_high_i(lph), .vco_tick_i(vt),
        .ext_clk_tick_i(1'b0), .vco_cal_done_i(cal_done), .charge_pump_hiz_o(hiz),
        .b_counter_reset_o(brst), .digital_lock_detect_o(digital_lock_detect), .selected_ref_o(selref),
        .lock_pin_level_o(lvl), .lock_pin_source_o(src), .lock_pin_discharge_o(dis),
        .reference_monitor_pin_o(mon), .first_reference_buf_en_o(b1), .second_reference_buf_en_o(b2));

    pho_loop_model loop_u (
        .core_clk_i(clk), .reset_n_i(rst_n), .ref_on_i(ref_on), .in_win_i(in_win),
        .src_i(src), .dis_i(dis), .first_reference_edge_o(r1), .pfd_cycle_o(pc), .in_win_o(iw),
        .over_win_o(ow), .lock_pin_high_o(lph), .vco_tick_o(vt));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] expv);
        compares++;
        if (seen !== expv)
        begin
            num_errors++;
            $display("BAD %0t seen %h want %h", $time, seen, expv);
        end
    endtask

    task automatic print_verdict();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Bounded wait on hiz (sel 0) or lock detect (sel 1)
    task automatic wait_for(input int sel, input logic val, input int bound);
        for (int i = 0; i < bound; i++)
        begin
            @(posedge clk);
            #1;
            if ((sel == 0 ? hiz : digital_lock_detect) === val)
                return;
        end
        num_errors++;
        $display("BAD %0t wait ran out", $time);
        print_verdict();
    endtask

    task automatic hold(input logic val, input int k);
        repeat (k)
        begin
            @(posedge clk);
            #1;
            check(8'(hiz), 8'(val));
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        {wr, rd, in_win, cal_done} = 4'h0;
        {sync_n, ref_on} = 2'b11;
        addr = 8'h00;
        wdata = 8'h00;
        num_errors = 0;
        compares = 0;
        cyc(8);
        rst_n <= 1'b1;
        foreach (ROWS[i])
        begin
            wr_reg(ROWS[i].addr, ROWS[i].wdata);
            rd_reg(ROWS[i].addr, v);
            check(v, ROWS[i].want);
        end
        check(8'({b2, b1}), 8'h03);
        // Second reset in mid-run must clear everything written above
        @(posedge clk);
        rst_n <= 1'b0;
        cyc(8);
        rst_n <= 1'b1;
        foreach (ROWS[i])
        begin
            rd_reg(ROWS[i].addr, v);
            check(v, 8'h00);
        end
        check(8'({hiz, brst, b1, b2}), 8'h00);
        wr_reg(8'h18, 8'h00);
        wr_reg(8'h1a, 8'h04);
        wr_reg(8'h1b, 8'hf7);
        wr_reg(8'h1c, 8'h06);
        in_win <= 1'b1;
        n = 0;
        repeat (60)
        begin
            #1;
            if (digital_lock_detect === 1'b1)
                break;
            if (pc === 1'b1)
                n++;
            @(posedge clk);
        end
        check(8'(n), 8'h05);
        cyc(3);
        check(8'({lvl, src, dis}), 8'h02);
        cyc(8);
        cal_done <= 1'b1;
        wr_reg(8'h1d, 8'h0d);
        hold(1'b0, 12);
        // Last detector cycle misses the window, then the reference dies
        in_win <= 1'b0;
        repeat (8)
        begin
            @(posedge clk);
            #1;
            if (pc === 1'b1)
                break;
        end
        @(posedge clk);
        ref_on <= 1'b0;
        wait_for(0, 1'b1, 10);
        check(8'({hiz, digital_lock_detect}), 8'h02);
        hold(1'b1, 45);
        rd_reg(8'h1f, v);
        check(v, 8'h52);
        check(8'(mon), 8'h01);
        ref_on <= 1'b1;
        wait_for(0, 1'b0, 12);
        check(8'(brst), 8'h01);
        hold(1'b0, 30);
        in_win <= 1'b1;
        wr_reg(8'h1d, 8'h05);
        wait_for(1, 1'b1, 40);
        cyc(8);
        in_win <= 1'b0;
        wait_for(1, 1'b0, 8);
        cyc(2);
        check(8'({lvl, src, dis}), 8'h01);
        hold(1'b0, 20);
        // Manual mode: a level held low while disabled must not trigger
        wr_reg(8'h1d, 8'h02);
        sync_n <= 1'b0;
        wr_reg(8'h1d, 8'h07);
        hold(1'b0, 8);
        sync_n <= 1'b1;
        cyc(2);
        sync_n <= 1'b0;
        wait_for(0, 1'b1, 3);
        hold(1'b1, 12);
        sync_n <= 1'b1;
        wait_for(0, 1'b0, 8);
        check(8'(brst), 8'h01);
        foreach (OFF_CODES[i])
        begin
            wr_reg(8'h1d, OFF_CODES[i]);
            sync_n <= 1'b0;
            hold(1'b0, 6);
            sync_n <= 1'b1;
            cyc(2);
        end
        wr_reg(8'h1c, 8'h16);
        cyc(2);
        check(8'(selref), 8'h01);
        print_verdict();
    end
endmodule
